// >>> src/src_cfg.svh
// Constants for the suspend and resume control block and its controller.
`ifndef SRC_CFG_SVH
`define SRC_CFG_SVH

// ==========================================================================
// Timing
`define SRC_CLK_MHZ 250
`define SRC_IDLE_US 3000
`define SRC_POWER_OFF_SUSPEND_MODE_US 2000
`define SRC_RESUME_K_US 20000
`define SRC_REMOTE_K_US 10000
`define SRC_WAKE_MAX_US 15000
`define SRC_OSC_US 1000
`define SRC_IDLE_CYC (`SRC_IDLE_US * `SRC_CLK_MHZ)
`define SRC_POWER_OFF_SUSPEND_MODE_CYC (`SRC_POWER_OFF_SUSPEND_MODE_US * `SRC_CLK_MHZ)
`define SRC_RESUME_K_CYC (`SRC_RESUME_K_US * `SRC_CLK_MHZ)
`define SRC_REMOTE_K_CYC (`SRC_REMOTE_K_US * `SRC_CLK_MHZ)
`define SRC_OSC_CYC (`SRC_OSC_US * `SRC_CLK_MHZ)

// ==========================================================================
// Device register offsets
`define SRC_DEV_STATUS 8'h00
`define SRC_DEV_IE 8'h01
`define SRC_DEV_MODE 8'h02
`define SRC_DEV_HWCFG 8'h03
`define SRC_DEV_UNLOCK 8'h04
`define SRC_UNLOCK_KEY 16'haa37

// ==========================================================================
// Device field positions
`define SRC_ST_SUSP 0
`define SRC_ST_RESUME 1
`define SRC_ST_BUSIDLE 2
`define SRC_MODE_PULLUP 0
`define SRC_MODE_TRIG 1
`define SRC_HW_INTERNAL_CLOCK_RUN 0
`define SRC_HW_CSWAKE 1
`define SRC_HW_PULLUP_SOURCE_SELECT 2
`define SRC_HW_POWER_OFF_SUSPEND_MODE 3
`define SRC_HW_RESET 4'h1

// ==========================================================================
// Controller register offsets and fields
`define SRC_CTL_CFG 8'h00
`define SRC_CTL_CMD 8'h01
`define SRC_CTL_STAT 8'h02
`define SRC_CTL_IMASK 8'h03
`define SRC_CFG_PULLUP 0
`define SRC_CFG_SUSPIE 1
`define SRC_CFG_RESIE 2
`define SRC_CFG_CSWAKE 3
`define SRC_CFG_PULLUP_SOURCE_SELECT 4
`define SRC_CFG_POWER_OFF_SUSPEND_MODE 5
`define SRC_CMD_WAKE 0
`define SRC_EV_SUSP 0
`define SRC_EV_ABORT 1
`define SRC_EV_RESUME 2
`define SRC_STAT_SLEEP 3
`define SRC_STAT_SUSPIN 4
`define SRC_STAT_BUSY 5

`endif

// >>> src/src_pkg.sv
// Types shared by the suspend and resume control ends.
package src_pkg;

  // ========================================================================
  // Device power states
  typedef enum logic [1:0] {
    SRC_D_AWAKE = 2'b00,
    SRC_D_SUSP = 2'b01,
    SRC_D_WAKE = 2'b10
  } src_dev_state_t;

  // ========================================================================
  // Controller sequence states
  typedef enum logic [3:0] {
    SRC_C_IDLE = 4'b0000,
    SRC_C_PUSH_IE = 4'b0001,
    SRC_C_PUSH_HW = 4'b0010,
    SRC_C_PUSH_MODE = 4'b0011,
    SRC_C_READ = 4'b0100,
    SRC_C_EVAL = 4'b0101,
    SRC_C_CLKOFF = 4'b0110,
    SRC_C_TRIG_HI = 4'b0111,
    SRC_C_TRIG_LO = 4'b1000,
    SRC_C_SLEEP = 4'b1001,
    SRC_C_UNLOCK = 4'b1010
  } src_ctl_state_t;

endpackage

// >>> src/src_link_if.sv
// Register link between the suspend and resume device and its controller.
`timescale 1ns/1ns
`default_nettype none
interface src_link_if;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic cs_n;
  logic irq;
  logic suspend;

  modport dev (
    input addr, wdata, wr, rd, cs_n,
    output rdata, irq, suspend
  );
  modport ctl (
    output addr, wdata, wr, rd, cs_n,
    input rdata, irq, suspend
  );
endinterface
`default_nettype wire

// >>> src/src_device.sv
// Suspend and resume control of a full-speed USB peripheral.
`include "src_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module src_device
  import src_pkg::*;
#(
  parameter int IDLE_CYC = `SRC_IDLE_CYC,
  parameter int POWER_OFF_SUSPEND_MODE_CYC = `SRC_POWER_OFF_SUSPEND_MODE_CYC,
  parameter int RESUME_K_CYC = `SRC_RESUME_K_CYC,
  parameter int REMOTE_K_CYC = `SRC_REMOTE_K_CYC,
  parameter int OSC_CYC = `SRC_OSC_CYC
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Register link to the controller
  src_link_if.dev link,
  // USB line state and wake pins
  input wire logic usb_idle_in,
  input wire logic usb_k_in,
  input wire logic remote_wake_input_in,
  input wire logic vbus_in,
  // Bus drive and power control
  output logic drive_k_out,
  output logic pullup_int_out,
  output logic pullup_ext_out,
  output logic osc_enable_out,
  output logic clock_dist_out
);

  localparam int CW = 24;

  // ========================================================================
  // Pin synchronisers
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic s_idle;
  logic s_k;
  logic s_wake;
  logic s_vbus;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {vbus_in, remote_wake_input_in, usb_k_in, usb_idle_in};
      sync2_q <= sync1_q;
    end
  end

  assign s_idle = sync2_q[0];
  assign s_k = sync2_q[1];
  assign s_wake = sync2_q[2];
  assign s_vbus = sync2_q[3];

  // Saturating increment shared by the timers.
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // ========================================================================
  // Bus idle detection
  logic [CW-1:0] idle_cnt_q;
  logic bus_susp;
  logic bus_susp_q;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      idle_cnt_q <= '0;
    end else if (s_idle) begin
      idle_cnt_q <= sat_inc(idle_cnt_q);
    end else begin
      idle_cnt_q <= '0;
    end
  end

  assign bus_susp = idle_cnt_q > CW'(IDLE_CYC);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bus_susp_q <= 1'b0;
    end else begin
      bus_susp_q <= bus_susp;
    end
  end

  // ========================================================================
  // Registers
  src_dev_state_t state_q;
  logic [CW-1:0] timer_q;
  logic [CW-1:0] hostk_cnt_q;
  logic [CW-1:0] remk_cnt_q;
  logic susp_flag_q;
  logic res_flag_q;
  logic [1:0] ie_q;
  logic [1:0] mode_q;
  logic [3:0] hw_q;
  logic locked_q;
  logic trig_prev_q;
  logic susp_pin_q;
  logic [15:0] rdata_q;
  logic wr_ok;
  logic rd_status;
  logic trig_fall;
  logic wake_done;
  logic power_off_suspend_mode_done;
  logic host_resume;
  logic cs_resume;
  logic resume;

  assign wr_ok = link.wr &&
                 (!locked_q || link.addr == `SRC_DEV_UNLOCK);
  assign rd_status = link.rd && link.addr == `SRC_DEV_STATUS;
  assign trig_fall = trig_prev_q && !mode_q[`SRC_MODE_TRIG];
  assign wake_done = state_q == SRC_D_WAKE && timer_q >= CW'(OSC_CYC);
  assign power_off_suspend_mode_done = state_q == SRC_D_SUSP && hw_q[`SRC_HW_POWER_OFF_SUSPEND_MODE] &&
                       timer_q >= CW'(POWER_OFF_SUSPEND_MODE_CYC);
  assign host_resume = hostk_cnt_q >= CW'(RESUME_K_CYC);
  assign cs_resume = hw_q[`SRC_HW_CSWAKE] && !link.cs_n && s_vbus;
  assign resume = host_resume || s_wake || cs_resume;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ie_q <= 2'h0;
      mode_q <= 2'h0;
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= mode_q[`SRC_MODE_TRIG];
      if (wr_ok && link.addr == `SRC_DEV_IE) begin
        ie_q <= link.wdata[1:0];
      end
      if (wr_ok && link.addr == `SRC_DEV_MODE) begin
        mode_q <= link.wdata[1:0];
      end
    end
  end

  // Clock run is restored by hardware once the oscillator has settled.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      hw_q <= `SRC_HW_RESET;
    end else begin
      if (wr_ok && link.addr == `SRC_DEV_HWCFG) begin
        hw_q <= link.wdata[3:0];
      end
      if (wake_done) begin
        hw_q[`SRC_HW_INTERNAL_CLOCK_RUN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      locked_q <= 1'b0;
    end else if (wake_done) begin
      locked_q <= 1'b1;
    end else if (wr_ok && link.addr == `SRC_DEV_UNLOCK &&
                 link.wdata == `SRC_UNLOCK_KEY) begin
      locked_q <= 1'b0;
    end
  end

  // A set in the cycle of the clearing read wins.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      susp_flag_q <= 1'b0;
      res_flag_q <= 1'b0;
    end else begin
      susp_flag_q <= (susp_flag_q && !rd_status) ||
                     (bus_susp && !bus_susp_q);
      res_flag_q <= (res_flag_q && !rd_status) || wake_done;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_q <= 16'h0000;
    end else if (link.rd) begin
      case (link.addr)
        `SRC_DEV_STATUS: begin
          rdata_q <= {13'h0000, bus_susp, res_flag_q, susp_flag_q};
        end
        `SRC_DEV_IE: rdata_q <= {14'h0000, ie_q};
        `SRC_DEV_MODE: rdata_q <= {14'h0000, mode_q};
        `SRC_DEV_HWCFG: rdata_q <= {12'h000, hw_q};
        `SRC_DEV_UNLOCK: rdata_q <= {15'h0000, locked_q};
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  // ========================================================================
  // Suspend and wake sequence
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= SRC_D_AWAKE;
      timer_q <= '0;
    end else begin
      case (state_q)
        SRC_D_AWAKE: begin
          timer_q <= '0;
          if (trig_fall) begin
            state_q <= SRC_D_SUSP;
          end
        end
        SRC_D_SUSP: begin
          timer_q <= sat_inc(timer_q);
          if (resume) begin
            state_q <= SRC_D_WAKE;
            timer_q <= '0;
          end
        end
        SRC_D_WAKE: begin
          timer_q <= sat_inc(timer_q);
          if (wake_done) begin
            state_q <= SRC_D_AWAKE;
          end
        end
        default: state_q <= SRC_D_AWAKE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      hostk_cnt_q <= '0;
    end else if (state_q == SRC_D_SUSP && s_k) begin
      hostk_cnt_q <= sat_inc(hostk_cnt_q);
    end else begin
      hostk_cnt_q <= '0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      susp_pin_q <= 1'b0;
    end else if (power_off_suspend_mode_done) begin
      susp_pin_q <= 1'b1;
    end else if (state_q != SRC_D_SUSP) begin
      susp_pin_q <= 1'b0;
    end
  end

  // Remote wake K runs from the start of the wake for its full length.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      remk_cnt_q <= '0;
    end else if (state_q == SRC_D_SUSP && resume && !host_resume &&
                 (s_wake || cs_resume)) begin
      remk_cnt_q <= CW'(REMOTE_K_CYC);
    end else if (remk_cnt_q != '0) begin
      remk_cnt_q <= remk_cnt_q - 1'b1;
    end
  end

  // ========================================================================
  // Outputs
  assign link.rdata = rdata_q;
  assign link.suspend = susp_pin_q;
  assign link.irq = (susp_flag_q && ie_q[0]) || (res_flag_q && ie_q[1]);
  assign drive_k_out = remk_cnt_q != '0;
  assign pullup_int_out = mode_q[`SRC_MODE_PULLUP] &&
                          !hw_q[`SRC_HW_PULLUP_SOURCE_SELECT];
  assign pullup_ext_out = mode_q[`SRC_MODE_PULLUP] &&
                          hw_q[`SRC_HW_PULLUP_SOURCE_SELECT];
  assign osc_enable_out = !susp_pin_q;
  assign clock_dist_out = state_q != SRC_D_WAKE && !susp_pin_q &&
                          hw_q[`SRC_HW_INTERNAL_CLOCK_RUN];

endmodule
`default_nettype wire

// >>> src/src_controller.sv
// Firmware-side sequencer that services suspend and resume of the device.
`include "src_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module src_controller
  import src_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Register link to the device
  src_link_if.ctl link,
  // Software register port
  input wire logic [7:0] sw_addr_in,
  input wire logic [15:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [15:0] sw_rdata_out,
  // Interrupt
  output logic irq_out
);

  src_ctl_state_t state_q;
  logic [5:0] cfg_q;
  logic [2:0] ev_q;
  logic [2:0] mask_q;
  logic push_q;
  logic wake_q;
  logic [15:0] sw_rdata_q;
  logic ev_susp;
  logic ev_abort;
  logic ev_resume;
  logic rd_stat;

  // Hardware configuration word with the clock run bit given.
  function automatic logic [15:0] hw_word(input logic run);
    hw_word = {12'h000, cfg_q[`SRC_CFG_POWER_OFF_SUSPEND_MODE], cfg_q[`SRC_CFG_PULLUP_SOURCE_SELECT],
               cfg_q[`SRC_CFG_CSWAKE], run};
  endfunction

  // ========================================================================
  // Sequence
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= SRC_C_IDLE;
    end else begin
      case (state_q)
        SRC_C_IDLE: begin
          if (link.irq) begin
            state_q <= SRC_C_READ;
          end else if (push_q) begin
            state_q <= SRC_C_PUSH_IE;
          end
        end
        SRC_C_PUSH_IE: state_q <= SRC_C_PUSH_HW;
        SRC_C_PUSH_HW: state_q <= SRC_C_PUSH_MODE;
        SRC_C_PUSH_MODE: state_q <= SRC_C_IDLE;
        SRC_C_READ: state_q <= SRC_C_EVAL;
        SRC_C_EVAL: begin
          if (link.rdata[`SRC_ST_RESUME]) begin
            state_q <= SRC_C_UNLOCK;
          end else if (link.rdata[`SRC_ST_SUSP] &&
                       link.rdata[`SRC_ST_BUSIDLE]) begin
            state_q <= SRC_C_CLKOFF;
          end else begin
            state_q <= SRC_C_IDLE;
          end
        end
        SRC_C_CLKOFF: state_q <= SRC_C_TRIG_HI;
        SRC_C_TRIG_HI: state_q <= SRC_C_TRIG_LO;
        SRC_C_TRIG_LO: state_q <= SRC_C_SLEEP;
        SRC_C_SLEEP: begin
          if (link.irq) begin
            state_q <= SRC_C_READ;
          end
        end
        SRC_C_UNLOCK: state_q <= SRC_C_PUSH_IE;
        default: state_q <= SRC_C_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Device bus drive
  always_comb begin
    link.addr = 8'h00;
    link.wdata = 16'h0000;
    link.wr = 1'b0;
    link.rd = 1'b0;
    case (state_q)
      SRC_C_PUSH_IE: begin
        link.wr = 1'b1;
        link.addr = `SRC_DEV_IE;
        link.wdata = {14'h0000, cfg_q[`SRC_CFG_RESIE], cfg_q[`SRC_CFG_SUSPIE]};
      end
      SRC_C_PUSH_HW: begin
        link.wr = 1'b1;
        link.addr = `SRC_DEV_HWCFG;
        link.wdata = hw_word(1'b1);
      end
      SRC_C_PUSH_MODE, SRC_C_TRIG_LO: begin
        link.wr = 1'b1;
        link.addr = `SRC_DEV_MODE;
        link.wdata = {15'h0000, cfg_q[`SRC_CFG_PULLUP]};
      end
      SRC_C_READ: begin
        link.rd = 1'b1;
        link.addr = `SRC_DEV_STATUS;
      end
      SRC_C_CLKOFF: begin
        link.wr = 1'b1;
        link.addr = `SRC_DEV_HWCFG;
        link.wdata = hw_word(1'b0);
      end
      SRC_C_TRIG_HI: begin
        link.wr = 1'b1;
        link.addr = `SRC_DEV_MODE;
        link.wdata = {14'h0000, 1'b1, cfg_q[`SRC_CFG_PULLUP]};
      end
      SRC_C_UNLOCK: begin
        link.wr = 1'b1;
        link.addr = `SRC_DEV_UNLOCK;
        link.wdata = `SRC_UNLOCK_KEY;
      end
      default: begin
        link.wr = 1'b0;
      end
    endcase
  end

  assign link.cs_n = !(link.wr || link.rd || wake_q);

  // ========================================================================
  // Software registers and events
  assign ev_susp = state_q == SRC_C_TRIG_LO;
  assign ev_abort = state_q == SRC_C_EVAL && !link.rdata[`SRC_ST_RESUME] &&
                    link.rdata[`SRC_ST_SUSP] && !link.rdata[`SRC_ST_BUSIDLE];
  assign ev_resume = state_q == SRC_C_UNLOCK;
  assign rd_stat = sw_rd_in && sw_addr_in == `SRC_CTL_STAT;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_q <= 6'h00;
      mask_q <= 3'h0;
    end else if (sw_wr_in) begin
      if (sw_addr_in == `SRC_CTL_CFG) begin
        cfg_q <= sw_wdata_in[5:0];
      end
      if (sw_addr_in == `SRC_CTL_IMASK) begin
        mask_q <= sw_wdata_in[2:0];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      push_q <= 1'b0;
    end else if (sw_wr_in && sw_addr_in == `SRC_CTL_CFG) begin
      push_q <= 1'b1;
    end else if (state_q == SRC_C_PUSH_IE) begin
      push_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wake_q <= 1'b0;
    end else if (state_q != SRC_C_SLEEP) begin
      wake_q <= 1'b0;
    end else if (sw_wr_in && sw_addr_in == `SRC_CTL_CMD &&
                 sw_wdata_in[`SRC_CMD_WAKE]) begin
      wake_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ev_q <= 3'h0;
    end else begin
      ev_q <= (ev_q & {3{!rd_stat}}) | {ev_resume, ev_abort, ev_susp};
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sw_rdata_q <= 16'h0000;
    end else if (sw_rd_in) begin
      case (sw_addr_in)
        `SRC_CTL_CFG: sw_rdata_q <= {10'h000, cfg_q};
        `SRC_CTL_STAT: begin
          sw_rdata_q <= {10'h000, state_q != SRC_C_IDLE &&
                         state_q != SRC_C_SLEEP, link.suspend,
                         state_q == SRC_C_SLEEP, ev_q};
        end
        `SRC_CTL_IMASK: sw_rdata_q <= {13'h0000, mask_q};
        default: sw_rdata_q <= 16'h0000;
      endcase
    end
  end

  assign sw_rdata_out = sw_rdata_q;
  assign irq_out = |(ev_q & mask_q);

endmodule
`default_nettype wire

// >>> verif/src_assertions.sv
// Concurrent checks on the register link between device and controller.
`timescale 1ns/1ns
`default_nettype none
module src_assertions #(
  parameter int POWER_OFF_SUSPEND_MODE_CYC = 20,
  parameter int OSC_CYC = 10
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Link signals
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic cs_n,
  input wire logic irq,
  input wire logic suspend
);
  localparam int WAKE_MAX = OSC_CYC + 40;
  logic clk_off_q;
  logic [15:0] since_lo_q;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  // ==========================================================================
  // Helper state
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      clk_off_q <= 1'b0;
    end else if (wr && addr == 8'h03) begin
      clk_off_q <= !wdata[0];
    end
  end

  // Counts cycles since the last mode write with the trigger bit low.
  always_ff @(posedge clock_in) begin
    if (rst_in || (wr && addr == 8'h02 && !wdata[1])) begin
      since_lo_q <= 16'h0000;
    end else if (since_lo_q != 16'hffff) begin
      since_lo_q <= since_lo_q + 16'h0001;
    end
  end

  // ==========================================================================
  // Sequences
  sequence s_trig_hi;
    wr && addr == 8'h02 && wdata[1];
  endsequence
  sequence s_trig_lo;
    wr && addr == 8'h02 && !wdata[1];
  endsequence
  sequence s_clk_off;
    wr && addr == 8'h03 && !wdata[0];
  endsequence
  sequence s_stat_rd;
    rd && addr == 8'h00;
  endsequence

  // ==========================================================================
  // Properties
  property p_unlock_key;
    wr && addr == 8'h04 |-> wdata == 16'haa37;
  endproperty
  a_unlock_key: assert property (p_unlock_key)
    else $error("unlock write without key");

  property p_trig_pair;
    s_trig_hi |=> ##[0:3] s_trig_lo;
  endproperty
  a_trig_pair: assert property (p_trig_pair)
    else $error("trigger set without clear");

  property p_clkoff_first;
    s_trig_hi |-> clk_off_q;
  endproperty
  a_clkoff_first: assert property (p_clkoff_first)
    else $error("trigger before clock stop");

  property p_power_off_suspend_mode_delay;
    $rose(suspend) |-> since_lo_q >= 16'(POWER_OFF_SUSPEND_MODE_CYC) &&
      since_lo_q <= 16'(POWER_OFF_SUSPEND_MODE_CYC + 6);
  endproperty
  a_power_off_suspend_mode_delay: assert property (p_power_off_suspend_mode_delay)
    else $error("suspend pin delay wrong");

  property p_irq_service;
    $rose(irq) |-> ##[0:12] s_stat_rd;
  endproperty
  a_irq_service: assert property (p_irq_service)
    else $error("interrupt not serviced");

  property p_abort;
    s_stat_rd ##1 (rdata[0] && !rdata[2]) |=>
      (!(wr && addr == 8'h02 && wdata[1])) [*8];
  endproperty
  a_abort: assert property (p_abort)
    else $error("suspend entered with bus active");

  property p_susp_go;
    s_stat_rd ##1 (rdata[0] && rdata[2] && !rdata[1]) |-> ##[1:4] s_clk_off;
  endproperty
  a_susp_go: assert property (p_susp_go)
    else $error("suspend entry not started");

  property p_rdata_stand;
    !rd |=> $stable(rdata);
  endproperty
  a_rdata_stand: assert property (p_rdata_stand)
    else $error("read data changed without read");

  property p_wake_unlock;
    $fell(suspend) |-> ##[1:WAKE_MAX] (wr && addr == 8'h04);
  endproperty
  a_wake_unlock: assert property (p_wake_unlock)
    else $error("no unlock after wake");
endmodule
`default_nettype wire

// >>> verif/usb_suspend_resume_control_tb.sv
// Self-checking bench for the suspend and resume device and controller.
`timescale 1ns/1ns
`default_nettype none
module usb_suspend_resume_control_tb;
  localparam int IDLE = 40;
  localparam int POWER_OFF_SUSPEND_MODE = 20;
  localparam int RESK = 30;
  localparam int REMK = 25;
  localparam int OSC = 10;
  logic clock_in, rst_in, sw_wr, sw_rd, irq_out;
  logic [7:0] sw_addr;
  logic [15:0] sw_wdata, sw_rdata, rd_val;
  logic usb_idle, usb_k, wake, vbus;
  logic drive_k, pu_int, pu_ext, osc_en, clk_dist;
  int num_errors = 0;
  int check_count = 0;
  int k_cnt = 0;
  int k0 = 0;

  // ==========================================================================
  // Design pair
  src_link_if src_link_if_i ();
  src_device #(.IDLE_CYC(IDLE), .POWER_OFF_SUSPEND_MODE_CYC(POWER_OFF_SUSPEND_MODE), .RESUME_K_CYC(RESK),
    .REMOTE_K_CYC(REMK), .OSC_CYC(OSC)) src_device_i (
    .clock_in(clock_in), .rst_in(rst_in), .link(src_link_if_i),
    .usb_idle_in(usb_idle), .usb_k_in(usb_k), .remote_wake_input_in(wake),
    .vbus_in(vbus), .drive_k_out(drive_k), .pullup_int_out(pu_int),
    .pullup_ext_out(pu_ext), .osc_enable_out(osc_en),
    .clock_dist_out(clk_dist));
  src_controller src_controller_i (
    .clock_in(clock_in), .rst_in(rst_in), .link(src_link_if_i),
    .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr),
    .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata), .irq_out(irq_out));
  src_assertions #(.POWER_OFF_SUSPEND_MODE_CYC(POWER_OFF_SUSPEND_MODE), .OSC_CYC(OSC)) src_assertions_i (
    .clock_in(clock_in), .rst_in(rst_in), .addr(src_link_if_i.addr),
    .wdata(src_link_if_i.wdata), .wr(src_link_if_i.wr),
    .rd(src_link_if_i.rd), .rdata(src_link_if_i.rdata),
    .cs_n(src_link_if_i.cs_n), .irq(src_link_if_i.irq),
    .suspend(src_link_if_i.suspend));

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    if (drive_k === 1'b1) begin
      k_cnt <= k_cnt + 1;
    end
  end

  // ==========================================================================
  // Access and check tasks
  task automatic sw_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_in);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clock_in);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock_in);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clock_in);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask

  task automatic check(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq_out !== 1'b1; i++) begin
      @(posedge clock_in);
      #1;
    end
    check("irq_out", 16'h0001, {15'h0, irq_out});
  endtask

  // Idle bus until the pair sleeps; pin is the expected suspend pin level.
  task automatic go_suspend(input logic pin);
    @(posedge clock_in);
    usb_idle <= 1'b1;
    wait_irq(IDLE + 60);
    sw_read(8'h02, rd_val);
    check("stat asleep", 16'h0009, rd_val & 16'h000f);
    repeat (POWER_OFF_SUSPEND_MODE + 10) @(posedge clock_in);
    usb_idle <= 1'b0;
    #1;
    check("suspend pin", 16'(pin), 16'(src_link_if_i.suspend));
    check("osc enable", {15'h0, !pin}, {15'h0, osc_en});
    sw_read(8'h02, rd_val);
    check("stat cleared", {11'h0, pin, 4'h8}, rd_val & 16'h001f);
    k0 = k_cnt;
  endtask

  task automatic wake_check(input int k_exp);
    wait_irq(OSC + 100);
    repeat (30) @(posedge clock_in);
    sw_read(8'h02, rd_val);
    check("stat awake", 16'h0004, rd_val & 16'h003f);
    check("remote K cycles", 16'(k_exp), 16'(k_cnt - k0));
    check("clocks back", 16'h0003, {14'h0, osc_en, clk_dist});
    check("pullup after unlock", 16'h0002, {14'h0, pu_int, pu_ext});
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #40000;
    num_errors++;
    $display("watchdog expired");
    complete_run();
  end

  // ==========================================================================
  // Tests
  initial begin
    rst_in = 1'b1;
    sw_addr = 8'h00;
    sw_wdata = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    usb_idle = 1'b0;
    usb_k = 1'b0;
    wake = 1'b0;
    vbus = 1'b1;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    sw_read(8'h00, rd_val);
    check("cfg reset", 16'h0000, rd_val);
    sw_read(8'h02, rd_val);
    check("stat reset", 16'h0000, rd_val);
    check("pullups reset", 16'h0000, {14'h0, pu_int, pu_ext});
    sw_write(8'h03, 16'h0007);
    sw_write(8'h0c, 16'hffff);
    sw_write(8'h00, 16'h0011);
    repeat (10) @(posedge clock_in);
    check("external pullup", 16'h0001, {14'h0, pu_int, pu_ext});
    sw_write(8'h00, 16'h0027);
    repeat (10) @(posedge clock_in);
    check("internal pullup", 16'h0002, {14'h0, pu_int, pu_ext});
    sw_read(8'h03, rd_val);
    check("mask", 16'h0007, rd_val);
    sw_read(8'h00, rd_val);
    check("cfg", 16'h0027, rd_val);
    $display("test registers done");
    go_suspend(1'b1);
    @(posedge clock_in);
    usb_k <= 1'b1;
    repeat (RESK - 20) @(posedge clock_in);
    usb_k <= 1'b0;
    repeat (20) @(posedge clock_in);
    #1;
    check("short K ignored", 16'h0001, {15'h0, src_link_if_i.suspend});
    @(posedge clock_in);
    usb_k <= 1'b1;
    repeat (RESK + 5) @(posedge clock_in);
    usb_k <= 1'b0;
    wake_check(0);
    $display("test host resume done");
    go_suspend(1'b1);
    @(posedge clock_in);
    wake <= 1'b1;
    repeat (4) @(posedge clock_in);
    wake <= 1'b0;
    wake_check(REMK);
    $display("test remote wake done");
    sw_write(8'h00, 16'h000f);
    vbus <= 1'b0;
    go_suspend(1'b0);
    sw_write(8'h01, 16'h0001);
    repeat (60) @(posedge clock_in);
    sw_read(8'h02, rd_val);
    check("no wake without bus power", 16'h0008, rd_val & 16'h001f);
    @(posedge clock_in);
    vbus <= 1'b1;
    wake_check(REMK);
    $display("test chip select wake done");
    sw_write(8'h00, 16'h000d);
    @(posedge clock_in);
    usb_idle <= 1'b1;
    repeat (IDLE + 20) @(posedge clock_in);
    usb_idle <= 1'b0;
    repeat (10) @(posedge clock_in);
    sw_read(8'h02, rd_val);
    check("stat masked", 16'h0000, rd_val & 16'h003f);
    sw_write(8'h00, 16'h000f);
    wait_irq(40);
    sw_read(8'h02, rd_val);
    check("stat aborted", 16'h0002, rd_val & 16'h003f);
    $display("test abort done");
    complete_run();
  end
endmodule
`default_nettype wire
